// *** hw/perf_counter_pkg.sv ***
// Functional notes
// [RULE_01] eight counters, group from two bits
// [RULE_02] group select clears all counters
// [RULE_03] user mode adds event count, max three
// [RULE_04] no counting in monitor mode
// [RULE_05] groups zero to two event sources
// [RULE_06] group three opcode ranges and vector ops
// [RULE_07] read delivers half selected by pointer
// [RULE_08] entering monitor mode clears pointer
// [RULE_09] pointer advances after each read
// [RULE_10] even: bits 0-25 to 32-57
// [RULE_11] odd: bits 26-45 to 38-57
// [RULE_12] issuer spaces reads two periods apart
// [RULE_13] bump adds at 0 and 6, or 26
// [RULE_14] pointer picks bump target, read moves it
// [RULE_15] issuer spaces bumps two periods apart
// [RULE_16] bump writes all ones to target
// [RULE_17] operations issued only in monitor mode
// [RULE_18] counters 46 bits, unused bits zero
// [RULE_19] four-bit wrapping pointer, reset clears all
package perf_counter_pkg;
   localparam int CNT_WIDTH     = 46;
   localparam int NUM_CNT       = 8;
   localparam int PTR_WIDTH     = 4;
   localparam int SREG_WIDTH    = 64;
   localparam int LO_WIDTH      = 26;
   localparam int HI_WIDTH      = 20;
   localparam int LO_DEST_POS   = 32;
   localparam int HI_DEST_POS   = 38;
   localparam int LO_SRC_POS    = 0;
   localparam int HI_SRC_POS    = 26;
   localparam int BUMP_EVEN_A   = 0;
   localparam int BUMP_EVEN_B   = 6;
   localparam int BUMP_ODD      = 26;
   localparam logic [1:0] GROUP_RESET = 2'h0;
   localparam logic [3:0] PTR_RESET   = 4'h0;
   // group numbers
   localparam logic [1:0] GRP_ISSUE = 2'h0;
   localparam logic [1:0] GRP_HOLD  = 2'h1;
   localparam logic [1:0] GRP_MEM   = 2'h2;
   localparam logic [1:0] GRP_OPC   = 2'h3;
   // opcode range limits for group three (octal figures)
   localparam logic [6:0] OPC_A_HI = 7'o17;
   localparam logic [6:0] OPC_B_HI = 7'o137;
   localparam logic [6:0] OPC_C_HI = 7'o157;
   localparam logic [6:0] OPC_C_X  = 7'o175;
   localparam logic [6:0] OPC_D_HI = 7'o174;
endpackage

// *** hw/perf_counters.sv ***
`timescale 1ns/1ps
module perf_counters
   import perf_counter_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  monitor_mode,
   input  wire logic                  group_select_op,
   input  wire logic [1:0]            group_field,
   input  wire logic                  counter_read_op,
   input  wire logic                  counter_bump_op,
   input  wire logic                  ev_issue,
   input  wire logic [6:0]            ev_opcode,
   input  wire logic                  ev_hold,
   input  wire logic                  ev_fetch,
   input  wire logic [1:0]            ev_io_ref,
   input  wire logic                  ev_cpu_ref,
   input  wire logic                  ev_fadd,
   input  wire logic                  ev_fmul,
   input  wire logic                  ev_frecip,
   input  wire logic [7:0]            ev_hold_cause,
   input  wire logic                  ev_scalar_ref,
   input  wire logic                  ev_scalar_conf,
   input  wire logic                  ev_io_conf,
   input  wire logic [1:0]            ev_block_ref,
   input  wire logic [1:0]            ev_block_conf,
   input  wire logic [1:0]            ev_vec_ref,
   input  wire logic [1:0]            ev_vec_int,
   input  wire logic [1:0]            ev_vec_flt,
   output logic      [SREG_WIDTH-1:0] sreg_data,
   output logic                       sreg_valid,
   output logic      [1:0]            group_sel,
   output logic      [PTR_WIDTH-1:0]  counter_ptr
);

   // counter bank and its next values, flip-flops addressed by index
   logic [CNT_WIDTH-1:0]  cnt_reg [NUM_CNT];
   logic [CNT_WIDTH-1:0]  cnt_next [NUM_CNT];
   logic [1:0]            group_reg, group_next;
   logic [PTR_WIDTH-1:0]  ptr_reg, ptr_next;
   // monitor mode as seen one period ago, to spot the entry
   logic                  mon_reg;
   logic [SREG_WIDTH-1:0] sdata_reg, sdata_next;
   logic                  svalid_reg, svalid_next;
   logic [1:0]            inc [NUM_CNT];
   logic [2:0]            sel_idx;
   logic [CNT_WIDTH-1:0]  sel_cnt;
   // first monitor cycle, and the pointer that an op in this cycle uses
   logic                  mon_entry;
   logic [PTR_WIDTH-1:0]  ptr_eff;

   // single-event sources add one at most; the multi-event sources are
   // already two bits wide
   function automatic logic [1:0] one(input logic b);
      return {1'b0, b};
   endfunction

   // opcode band with exclusive lower and inclusive upper limit, so the
   // package limits can be used as they stand
   function automatic logic opc_band(input logic [6:0] op,
                                     input logic [6:0] lo_excl,
                                     input logic [6:0] hi);
      return (op > lo_excl) && (op <= hi);
   endfunction

   // one-hot addend for the maintenance bump
   function automatic logic [CNT_WIDTH-1:0] bit_at(input int pos);
      return CNT_WIDTH'(1) << pos;
   endfunction

   // per-counter event amount for the selected group
   // [RULE_05] group event routing
   always_comb begin
      for (int i = 0; i < NUM_CNT; i++) begin
         inc[i] = 2'h0;
      end
      // each group wires the eight counters to its own mix of sources; fetch, io refs and vector refs are shared between groups
      case (group_reg)
         // group zero: issue, fetch and arithmetic traffic
         GRP_ISSUE: begin
            inc[0] = one(ev_issue);
            inc[1] = one(ev_hold);
            inc[2] = one(ev_fetch);
            inc[3] = ev_io_ref;
            inc[4] = one(ev_cpu_ref);
            inc[5] = one(ev_fadd);
            inc[6] = one(ev_fmul);
            inc[7] = one(ev_frecip);
         end
         // group one: one hold cause per counter
         GRP_HOLD: begin
            for (int i = 0; i < NUM_CNT; i++) begin
               inc[i] = one(ev_hold_cause[i]);
            end
         end
         // group two: memory references and conflicts
         GRP_MEM: begin
            inc[0] = one(ev_fetch);
            inc[1] = one(ev_scalar_ref);
            inc[2] = one(ev_scalar_conf);
            inc[3] = ev_io_ref;
            inc[4] = one(ev_io_conf);
            inc[5] = ev_block_ref;
            inc[6] = ev_block_conf;
            inc[7] = ev_vec_ref;
         end
         // [RULE_06] opcode range decode
         GRP_OPC: begin
            // opcodes above the fourth band other than the odd one go to counter four
            inc[0] = one(ev_issue && ev_opcode <= OPC_A_HI);
            inc[1] = one(ev_issue && opc_band(ev_opcode, OPC_A_HI, OPC_B_HI));
            inc[2] = one(ev_issue && (opc_band(ev_opcode, OPC_B_HI, OPC_C_HI) || ev_opcode == OPC_C_X));
            inc[3] = one(ev_issue && opc_band(ev_opcode, OPC_C_HI, OPC_D_HI));
            inc[4] = one(ev_issue && ev_opcode > OPC_C_X);
            inc[5] = ev_vec_int;
            inc[6] = ev_vec_flt;
            inc[7] = ev_vec_ref;
         end
         // two bits give four groups, so the default never acts
         default: ;
      endcase
   end

   // a monitor entry restarts the read sequence at once, so that an op
   // issued in the very first monitor cycle already sees pointer zero
   // [RULE_08] pointer cleared on monitor entry
   assign mon_entry = monitor_mode && !mon_reg;
   assign ptr_eff   = mon_entry ? PTR_RESET : ptr_reg;

   // counter and half addressed by the pointer
   assign sel_idx = ptr_eff[3:1];
   assign sel_cnt = cnt_reg[sel_idx];

   // next-state for counters, group, pointer and scalar result
   // ops coincide only if the issuer misbehaves; select then wins over
   // read, and read wins over bump
   always_comb begin
      group_next  = group_reg;
      ptr_next    = ptr_eff;
      sdata_next  = sdata_reg;   // result holds until the next read or bump
      svalid_next = 1'b0;

      // no saturation: at three per period a 46-bit total outlasts any run
      for (int i = 0; i < NUM_CNT; i++) begin
         cnt_next[i] = cnt_reg[i];
         // [RULE_03] add events in user mode
         // [RULE_04] frozen in monitor mode
         if (!monitor_mode) begin
            cnt_next[i] = cnt_reg[i] + {{(CNT_WIDTH-2){1'b0}}, inc[i]};
         end
      end

      // only honoured in monitor mode; issuer guarantees this anyway
      if (monitor_mode) begin
         // [RULE_01] latch two-bit group
         // [RULE_02] clear all counters
         if (group_select_op) begin
            group_next = group_field;
            for (int i = 0; i < NUM_CNT; i++) begin
               cnt_next[i] = '0;
            end
         end else if (counter_read_op) begin
            // [RULE_07] half chosen by pointer
            // [RULE_18] other bits zero
            sdata_next  = '0;
            svalid_next = 1'b1;
            if (!ptr_eff[0]) begin
               // [RULE_10] low half placement
               sdata_next[LO_DEST_POS +: LO_WIDTH] = sel_cnt[LO_SRC_POS +: LO_WIDTH];
            end else begin
               // [RULE_11] high half placement
               sdata_next[HI_DEST_POS +: HI_WIDTH] = sel_cnt[HI_SRC_POS +: HI_WIDTH];
            end
            // [RULE_09] advance, [RULE_19] wraps at fifteen
            ptr_next = ptr_eff + 4'h1;
         end else if (counter_bump_op) begin
            // [RULE_13] maintenance bump positions
            // [RULE_14] pointer picks target, unchanged
            // the wrap of a full counter is accepted
            if (!ptr_eff[0]) begin
               cnt_next[sel_idx] = sel_cnt + bit_at(BUMP_EVEN_A) + bit_at(BUMP_EVEN_B);
            end else begin
               cnt_next[sel_idx] = sel_cnt + bit_at(BUMP_ODD);
            end
            // [RULE_16] target register all ones
            sdata_next  = '1;
            svalid_next = 1'b1;
         end
      end
   end

   // registers; master clear resets everything
   // reset is synchronous and loads constants only
   // [RULE_19] master clear
   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_CNT; i++) begin
            cnt_reg[i] <= '0;
         end
         group_reg  <= GROUP_RESET;
         ptr_reg    <= PTR_RESET;
         mon_reg    <= 1'b0;
         sdata_reg  <= '0;
         svalid_reg <= 1'b0;
      end else begin
         cnt_reg    <= cnt_next;
         group_reg  <= group_next;
         ptr_reg    <= ptr_next;
         mon_reg    <= monitor_mode;
         sdata_reg  <= sdata_next;
         svalid_reg <= svalid_next;
      end
   end

   // outputs come straight from flip-flops
   // group and pointer are brought out for observation only
   assign sreg_data   = sdata_reg;
   assign sreg_valid  = svalid_reg;
   assign group_sel   = group_reg;
   assign counter_ptr = ptr_reg;

endmodule

// *** dv/issue_model.sv ***
`timescale 1ns/1ps
module issue_model (
   input  wire logic       clk,
   input  wire logic       monitor_mode,
   output logic            group_select_op,
   output logic [1:0]      group_field,
   output logic            counter_read_op,
   output logic            counter_bump_op
);
   initial {group_select_op, group_field, counter_read_op, counter_bump_op} = '0;
   // kind 0 select, 1 read, 2 bump; the field is scrambled once the pulse ends
   task automatic issue(input logic [1:0] kind, input logic [1:0] field);
      while (monitor_mode !== 1'b1) @(negedge clk);
      group_field = field;
      {group_select_op, counter_read_op, counter_bump_op} = 3'b100 >> kind;
      @(negedge clk);
      {group_select_op, counter_read_op, counter_bump_op} = 3'b000;
      group_field = ~field;
      repeat (2) @(negedge clk);
   endtask
endmodule

// *** dv/perf_counters_properties.sv ***
`timescale 1ns/1ps
module perf_counters_properties
   import perf_counter_pkg::*;
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        monitor_mode,
   input wire logic        group_select_op,
   input wire logic [1:0]  group_field,
   input wire logic        counter_read_op,
   input wire logic        counter_bump_op,
   input wire logic [63:0] sreg_data,
   input wire logic        sreg_valid,
   input wire logic [1:0]  group_sel,
   input wire logic [3:0]  counter_ptr
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // taken ops: select outranks read, read outranks bump
   sequence s_rd;
      monitor_mode && counter_read_op && !group_select_op;
   endsequence
   sequence s_bmp;
      monitor_mode && counter_bump_op && !group_select_op && !counter_read_op;
   endsequence
   // a read in the first monitor cycle already uses pointer zero
   sequence s_entry_rd;
      s_rd ##0 $rose(monitor_mode);
   endsequence
   a_group_latch: assert property (monitor_mode && group_select_op
      |=> group_sel == $past(group_field)) else $error("group not latched");
   a_lo_field: assert property (s_rd ##0 (!counter_ptr[0] || $rose(monitor_mode))
      |=> sreg_valid && sreg_data[31:0] == 0 && sreg_data[63:58] == 0) else $error("bad low read");
   a_hi_field: assert property (s_rd ##0 (counter_ptr[0] && !$rose(monitor_mode))
      |=> sreg_valid && sreg_data[37:0] == 0 && sreg_data[63:58] == 0) else $error("bad high read");
   a_ptr_step: assert property (s_rd ##0 !$rose(monitor_mode)
      |=> counter_ptr == $past(counter_ptr) + 4'h1) else $error("pointer not advanced");
   a_entry_read: assert property (s_entry_rd
      |=> counter_ptr == 4'h1 && sreg_valid && sreg_data[31:0] == 0) else $error("entry read not at zero");
   a_ptr_clear: assert property ($rose(monitor_mode) && !counter_read_op && $past(rstn)
      |=> counter_ptr == 4'h0) else $error("pointer not cleared");
   a_ptr_hold: assert property ($past(rstn) && !$rose(monitor_mode)
      && !(monitor_mode && counter_read_op && !group_select_op) |=> $stable(counter_ptr)) else $error("pointer moved");
   a_bump_ones: assert property (s_bmp |=> sreg_valid && sreg_data == '1)
      else $error("bump result wrong");
   a_valid_cause: assert property (!(monitor_mode && (counter_read_op || counter_bump_op) && !group_select_op)
      |=> !sreg_valid) else $error("stray valid");
endmodule
bind perf_counters perf_counters_properties u_props (.*);

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb
   import perf_counter_pkg::*;
;
   logic        clk = 1'b0, rstn = 1'b0, monitor_mode = 1'b1;
   logic        group_select_op, counter_read_op, counter_bump_op, sreg_valid;
   logic [1:0]  group_field, group_sel, ev_io_ref, ev_block_ref, ev_block_conf, ev_vec_ref, ev_vec_int, ev_vec_flt;
   logic        ev_issue, ev_hold, ev_fetch, ev_cpu_ref, ev_fadd, ev_fmul, ev_frecip, ev_scalar_ref, ev_scalar_conf;
   logic        ev_io_conf;
   logic [6:0]  ev_opcode;
   logic [7:0]  ev_hold_cause;
   logic [3:0]  counter_ptr, rd_ptr;
   logic [63:0] sreg_data, r, q[$];
   logic [45:0] cnt [8];
   int          cyc, n_mismatch = 0, num_checks = 0;
   perf_counters u_dut (.*);
   issue_model   u_issuer (.*);
   always #2.5 clk = ~clk;
   function automatic int cat(input logic [6:0] o);
      if (o <= OPC_A_HI) return 0;
      if (o <= OPC_B_HI) return 1;
      if (o <= OPC_C_HI || o == OPC_C_X) return 2;
      return (o <= OPC_D_HI) ? 3 : 4;
   endfunction
   // per-cycle increment of counter i in group g for the present events
   function automatic int inc(input int g, input int i);
      logic [1:0] v [8];
      if (g == 1) return int'(ev_hold_cause[i]);
      if (g == 3 && i < 5) return int'(ev_issue && cat(ev_opcode) == i);
      case (g)
         0: v = '{2'(ev_issue), 2'(ev_hold), 2'(ev_fetch), ev_io_ref, 2'(ev_cpu_ref), 2'(ev_fadd), 2'(ev_fmul),
                  2'(ev_frecip)};
         2: v = '{2'(ev_fetch), 2'(ev_scalar_ref), 2'(ev_scalar_conf), ev_io_ref, 2'(ev_io_conf), ev_block_ref,
                  ev_block_conf, ev_vec_ref};
         default: v = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, ev_vec_int, ev_vec_flt, ev_vec_ref};
      endcase
      return int'(v[i]);
   endfunction
   // io refs span the full multi-event range of 0 to 3
   task automatic rand_ev();
      r = {$urandom, $urandom};
      {ev_issue, ev_opcode, ev_hold, ev_fetch, ev_cpu_ref, ev_fadd, ev_fmul, ev_frecip, ev_hold_cause, ev_scalar_ref,
       ev_scalar_conf, ev_io_conf, ev_block_ref, ev_block_conf, ev_vec_ref, ev_vec_int, ev_vec_flt} = r[34:0];
      ev_io_ref = r[36:35];
   endtask
   task automatic rd();
      q.push_back(rd_ptr[0] ? {6'h0, cnt[rd_ptr[3:1]][45:26], 38'h0} : {6'h0, cnt[rd_ptr[3:1]][25:0], 32'h0});
      rd_ptr++;
      u_issuer.issue(2'h1, 2'h0);
   endtask
   task automatic bump();
      cnt[rd_ptr[3:1]] += rd_ptr[0] ? 46'h4000000 : 46'h41;
      q.push_back('1);
      u_issuer.issue(2'h2, 2'h0);
   endtask
   task automatic user_run(input int g, input int cycles);
      foreach (cnt[i]) cnt[i] += 46'(cycles * inc(g, i));
      monitor_mode = 1'b0;
      repeat (cycles) @(negedge clk);
      monitor_mode = 1'b1;
      rd_ptr = 4'h0;
   endtask
   task automatic cmp_data(input logic [63:0] exp);
      num_checks++;
      if (sreg_data !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: sreg_data %h expected %h", $time, sreg_data, exp);
      end
   endtask
   task automatic cmp_state(input logic [1:0] g_exp, input logic [3:0] p_exp);
      num_checks++;
      if (group_sel !== g_exp || counter_ptr !== p_exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: group %h pointer %h expected %h %h", $time, group_sel, counter_ptr, g_exp, p_exp);
      end
   endtask
   task automatic tally_and_finish();
      if (q.size() != 0) n_mismatch++;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // result watcher, looks once outputs have settled
   always @(negedge clk) if (sreg_valid === 1'b1) cmp_data(q.pop_front());
   // hang guard, run needs well under a thousand cycles
   always @(posedge clk) if (++cyc == 4000) begin
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h692C79DC));
      rand_ev();
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      for (int g = 0; g < 4; g++) begin
         u_issuer.issue(2'h0, 2'(g));
         foreach (cnt[i]) cnt[i] = '0;
         rand_ev();
         user_run(g, $urandom_range(40, 5));
         repeat (16) rd();
         cmp_state(2'(g), 4'h0);
         $display("group %0d test done", g);
      end
      bump();
      rd();
      bump();
      rd();
      user_run(3, 1);
      rd();
      rd();
      user_run(3, 2);
      @(negedge clk);
      rd();
      repeat (4) @(negedge clk);
      $display("bump and monitor entry test done");
      // master clear in mid-run
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      foreach (cnt[i]) cnt[i] = '0;
      rd_ptr = 4'h0;
      cmp_state(GROUP_RESET, PTR_RESET);
      rd();
      repeat (4) @(negedge clk);
      $display("master clear test done");
      tally_and_finish();
   end
endmodule
